// ### bench/srxcfg_link_model.sv
// Behavioural model of the link logic that feeds status and sync into the setup bank.
`timescale 1ns/10ps
module srxcfg_link_model #(
    parameter int SYNC_LAT = 4
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    output logic link_up_o,
    output logic crc_fault_o,
    output logic link_sync_n_o
);
    int up_cnt;

    // Mode 0 drops the link, 1 keeps it clean, 2 keeps it up with a CRC fault.
    // Sync is released only after the link has been up for a while, like a slow transmitter.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || mode_i == 2'h0) begin
            up_cnt <= 0;
        end else if (up_cnt < SYNC_LAT) begin
            up_cnt <= up_cnt + 1;
        end
        link_up_o <= !rst_i && mode_i != 2'h0;
        crc_fault_o <= !rst_i && mode_i == 2'h2;
        link_sync_n_o <= !rst_i && mode_i != 2'h0 && up_cnt >= SYNC_LAT;
    end
endmodule : srxcfg_link_model

// ### bench/testbench.sv
// Self-checking bench for the receiver PHY setup register bank.
`timescale 1ns/10ps
module testbench;
    import srxcfg_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic link_en = 1'b0;
    logic enc_sel = 1'b0;
    logic [1:0] mode = 2'h1;
    logic [31:0] prdata;
    logic [31:0] rdat;
    logic pready, pslverr, sync_n, div_ok, mult_ok, vco_low, prbs_act, rx_rst, pll_rst, rerr;
    logic link_up, crc_fault, link_sync_n;
    logic [5:0] divisor, mult_q2;
    logic [3:0] lane_q1;
    logic [4:0] prbs_sel;
    int miscompares = 0;
    int samples_checked = 0;
    int n_rx, n_pll;
    localparam logic [7:0] MPY_CODES [4] = '{8'h10, 8'h14, 8'h21, 8'h28};
    localparam logic [9:0] REG_IDX [7] = '{10'h108, 10'h109, 10'h10A, 10'h10B, 10'h120,
        10'h121, 10'h124};
    localparam logic [7:0] REG_RST [7] = '{8'h30, 8'h14, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};

    // The clock toggles every half period of 100 ns.
    always #50 ref_clk = ~ref_clk;

    srxcfg_top u_srxcfg_top (.ref_clk_i(ref_clk), .rst_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link_enable_i(link_en),
        .line_encoding_select_i(enc_sel), .link_up_i(link_up), .crc_fault_i(crc_fault),
        .link_sync_n_i(link_sync_n), .sync_n_o(sync_n), .ref_clock_divisor_o(divisor),
        .ref_divisor_legal_o(div_ok), .pll_multiplier_q2_o(mult_q2),
        .pll_multiplier_valid_o(mult_ok), .lane_multiplier_q1_o(lane_q1),
        .vco_low_band_o(vco_low), .prbs_test_select_o(prbs_sel), .prbs_active_o(prbs_act),
        .phy_rx_reset_o(rx_rst), .phy_pll_reset_o(pll_rst));

    srxcfg_link_model u_srxcfg_link_model (.ref_clk_i(ref_clk), .rst_i(rst), .mode_i(mode),
        .link_up_o(link_up), .crc_fault_o(crc_fault), .link_sync_n_o(link_sync_n));

    // ****************************************************************
    // Bus and comparison tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; waits for pready and takes the answer at that edge.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] data);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= data;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only the watchdog process ends a wait for an answer that never comes.
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Write, then let the decoded outputs settle.
    task automatic wr(input logic [9:0] idx, input logic [7:0] data);
        apb(1'b1, idx, {24'h0, data});
        repeat (3) @(posedge ref_clk);
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [7:0] exp, input string nm);
        apb(1'b0, idx, 32'h0);
        chk(nm, rdat, {24'h0, exp});
        chk("slverr", {31'h0, rerr}, 32'h0);
    endtask : rd

    // Runs the watchdog for 1200 cycles with the link in a given mode and counts resets.
    task automatic wd(input logic [7:0] cfg, input logic [1:0] m, input int erx, input int epl);
        wr(IDX_LINK_WATCHDOG_CONTROL, cfg);
        mode <= m;
        link_en <= 1'b1;
        n_rx = 0;
        n_pll = 0;
        repeat (1200) begin
            @(posedge ref_clk);
            n_rx += int'(rx_rst === 1'b1);
            n_pll += int'(pll_rst === 1'b1);
        end
        link_en <= 1'b0;
        chk("rx resets", n_rx, erx);
        chk("pll resets", n_pll, epl);
    endtask : wd

    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(REG_IDX[i], REG_RST[i], "reset value");
        end
        apb(1'b0, 10'h10C, 32'h0);
        chk("unmapped err", {31'h0, rerr}, 32'h1);
        chk("unmapped data", rdat, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_PHY_PLL_MULTIPLIER, MPY_CODES[i]);
            chk("mult", {mult_ok, mult_q2}, {1'b1, MPY_CODES[i][5:0]});
        end
        wr(IDX_PHY_PLL_MULTIPLIER, 8'h11);
        chk("mult bad", {mult_ok, mult_q2}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_LANE_RATE_MULTIPLIER, 8'(i));
            chk("lane", lane_q1, 32'h8 >> i);
        end
        for (int i = 0; i < 6; i++) begin
            wr(IDX_PRBS_TEST_CONTROL, 8'(i));
            chk("prbs", {prbs_act, prbs_sel}, i == 5 ? 32'h0 : {i != 0, 5'(i)});
        end
        wr(IDX_PHY_REF_DIVIDER, 8'h30);
        chk("div", {div_ok, divisor}, {1'b1, 6'h30});
        wr(IDX_PHY_REF_DIVIDER, 8'h07);
        chk("div bad", {div_ok, divisor}, {1'b0, 6'h07});
        wr(IDX_PLL_VCO_BAND, 8'h01);
        chk("vco", vco_low, 32'h1);
        repeat (8) @(posedge ref_clk);
        wr(IDX_MANUAL_LINK_REQUEST, 8'h00);
        chk("sync forced", sync_n, 32'h0);
        wr(IDX_MANUAL_LINK_REQUEST, 8'h01);
        chk("sync released", sync_n, 32'h1);
        mode <= 2'h0;
        repeat (3) @(posedge ref_clk);
        chk("sync follows", sync_n, 32'h0);
        wr(IDX_LINK_WATCHDOG_CONTROL, 8'hFF);
        rd(IDX_LINK_WATCHDOG_CONTROL, 8'hB7, "watchdog ctrl");
        wd(8'h81, 2'h0, 1, 1);
        wd(8'h01, 2'h0, 1, 0);
        wd(8'h00, 2'h0, 0, 0);
        wd(8'h31, 2'h1, 0, 0);
        wd(8'h01, 2'h2, 1, 0);
        conclude();
    end

    // Cuts a hung run short well after the tests should have ended.
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        conclude();
    end
endmodule : testbench

// ### hdl/srxcfg_pkg.sv
// Package of register map, field layout and watchdog constants for the receiver PHY setup bank.
package srxcfg_pkg;
    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [9:0] IDX_PHY_REF_DIVIDER = 10'h108;
    localparam logic [9:0] IDX_PHY_PLL_MULTIPLIER = 10'h109;
    localparam logic [9:0] IDX_LANE_RATE_MULTIPLIER = 10'h10A;
    localparam logic [9:0] IDX_PLL_VCO_BAND = 10'h10B;
    localparam logic [9:0] IDX_MANUAL_LINK_REQUEST = 10'h120;
    localparam logic [9:0] IDX_PRBS_TEST_CONTROL = 10'h121;
    localparam logic [9:0] IDX_LINK_WATCHDOG_CONTROL = 10'h124;
    localparam int ADDR_W = 12;
    localparam int IDX_LSB = 2;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [5:0] RST_REF_DIV = 6'h30;
    localparam logic [7:0] RST_PLL_MULT = 8'h14;
    localparam logic [1:0] RST_LANE_RATE = 2'h0;
    localparam logic RST_VCO_LOW = 1'b0;
    localparam logic RST_MANUAL_REQ_N = 1'b1;
    localparam logic [4:0] RST_PRBS_SEL = 5'h00;
    localparam logic [7:0] RST_WDOG_CTRL = 8'h00;

    // ****************************************************************
    // Watchdog control field positions
    // ****************************************************************
    localparam int WD_PLL_BIT = 7;
    localparam int WD_DEC_HI = 5;
    localparam int WD_DEC_LO = 4;
    localparam int WD_THR_HI = 2;
    localparam int WD_THR_LO = 0;

    // ****************************************************************
    // Decoded multiplier codes
    // ****************************************************************
    localparam logic [7:0] MPY_CODE_X4 = 8'h10;
    localparam logic [7:0] MPY_CODE_X5 = 8'h14;
    localparam logic [7:0] MPY_CODE_X8P25 = 8'h21;
    localparam logic [7:0] MPY_CODE_X10 = 8'h28;
    // Multiplier times four: 4, 5, 8.25 and 10.
    localparam logic [5:0] MPY_Q2_X4 = 6'h10;
    localparam logic [5:0] MPY_Q2_X5 = 6'h14;
    localparam logic [5:0] MPY_Q2_X8P25 = 6'h21;
    localparam logic [5:0] MPY_Q2_X10 = 6'h28;
    // Lane multiplier times two: 4, 2, 1 and 0.5.
    localparam logic [3:0] RATE_Q1_00 = 4'h8;
    localparam logic [3:0] RATE_Q1_01 = 4'h4;
    localparam logic [3:0] RATE_Q1_10 = 4'h2;
    localparam logic [3:0] RATE_Q1_11 = 4'h1;
    localparam logic [4:0] PRBS_LAST_CODE = 5'h04;

    // ****************************************************************
    // Watchdog counter
    // ****************************************************************
    localparam int WD_CNT_W = 33;
    localparam logic [WD_CNT_W-1:0] WD_DEC_0 = 33'h1;
    localparam logic [WD_CNT_W-1:0] WD_DEC_1 = 33'h2;
    localparam logic [WD_CNT_W-1:0] WD_DEC_2 = 33'h8;
    localparam logic [WD_CNT_W-1:0] WD_DEC_3 = 33'h10;
    localparam logic [WD_CNT_W-1:0] WD_INC_DOWN = 33'h80;
    localparam logic [WD_CNT_W-1:0] WD_THR_1 = 33'h0_0002_0000;
    localparam logic [WD_CNT_W-1:0] WD_THR_2 = 33'h0_0008_0000;
    localparam logic [WD_CNT_W-1:0] WD_THR_3 = 33'h1_0000_0000;
    localparam logic [WD_CNT_W-1:0] WD_THR_4 = 33'h0_0080_0000;
endpackage : srxcfg_pkg

// ### hdl/srxcfg_top.sv
// APB register bank for receiver PHY PLL, lane rate, sync request, PRBS and watchdog setup.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module srxcfg_top
    import srxcfg_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic link_enable_i,
    input wire logic line_encoding_select_i,
    input wire logic link_up_i,
    input wire logic crc_fault_i,
    input wire logic link_sync_n_i,
    output logic sync_n_o,
    output logic [5:0] ref_clock_divisor_o,
    output logic ref_divisor_legal_o,
    output logic [5:0] pll_multiplier_q2_o,
    output logic pll_multiplier_valid_o,
    output logic [3:0] lane_multiplier_q1_o,
    output logic vco_low_band_o,
    output logic [4:0] prbs_test_select_o,
    output logic prbs_active_o,
    output logic phy_rx_reset_o,
    output logic phy_pll_reset_o
);
    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [5:0] ref_clock_divisor;
    logic [7:0] pll_multiplier;
    logic [1:0] lane_rate;
    logic vco_low_band;
    logic manual_link_request_n;
    logic [4:0] prbs_test_select;
    logic watchdog_pll_reset_en;
    logic [1:0] watchdog_decrement_sel;
    logic [2:0] watchdog_threshold_sel;
    logic [9:0] index;
    logic access;
    logic hit;
    logic [7:0] read_value;
    logic [WD_CNT_W-1:0] wd_count;
    logic wd_rx_reset;
    logic wd_pll_reset;

    assign index = paddr_i[ADDR_W-1:IDX_LSB];
    assign access = psel_i & penable_i & ~pready_o;

    // Address decode and read mux; reserved bits read zero.
    always_comb begin
        hit = 1'b1;
        read_value = 8'h00;
        unique case (index)
            IDX_PHY_REF_DIVIDER: read_value = {2'h0, ref_clock_divisor};
            IDX_PHY_PLL_MULTIPLIER: read_value = pll_multiplier;
            IDX_LANE_RATE_MULTIPLIER: read_value = {6'h00, lane_rate};
            IDX_PLL_VCO_BAND: read_value = {7'h00, vco_low_band};
            IDX_MANUAL_LINK_REQUEST: read_value = {7'h00, manual_link_request_n};
            IDX_PRBS_TEST_CONTROL: read_value = {3'h0, prbs_test_select};
            IDX_LINK_WATCHDOG_CONTROL: begin
                read_value = {watchdog_pll_reset_en, 1'b0, watchdog_decrement_sel,
                              1'b0, watchdog_threshold_sel};
            end
            default: hit = 1'b0;
        endcase
    end

    // ****************************************************************
    // APB handshake: one wait state, answer registered
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end else begin
            pready_o <= access;
            pslverr_o <= access & ~hit;
            if (access && !pwrite_i) begin
                prdata_o <= {24'h000000, read_value};
            end
        end
    end

    // Register writes land at the completing edge of the access phase.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ref_clock_divisor <= RST_REF_DIV;
            pll_multiplier <= RST_PLL_MULT;
            lane_rate <= RST_LANE_RATE;
            vco_low_band <= RST_VCO_LOW;
            manual_link_request_n <= RST_MANUAL_REQ_N;
            prbs_test_select <= RST_PRBS_SEL;
            watchdog_pll_reset_en <= RST_WDOG_CTRL[WD_PLL_BIT];
            watchdog_decrement_sel <= RST_WDOG_CTRL[WD_DEC_HI:WD_DEC_LO];
            watchdog_threshold_sel <= RST_WDOG_CTRL[WD_THR_HI:WD_THR_LO];
        end else if (psel_i && penable_i && pready_o && pwrite_i) begin
            unique case (index)
                IDX_PHY_REF_DIVIDER: ref_clock_divisor <= pwdata_i[5:0];
                IDX_PHY_PLL_MULTIPLIER: pll_multiplier <= pwdata_i[7:0];
                IDX_LANE_RATE_MULTIPLIER: lane_rate <= pwdata_i[1:0];
                IDX_PLL_VCO_BAND: vco_low_band <= pwdata_i[0];
                IDX_MANUAL_LINK_REQUEST: manual_link_request_n <= pwdata_i[0];
                IDX_PRBS_TEST_CONTROL: prbs_test_select <= pwdata_i[4:0];
                IDX_LINK_WATCHDOG_CONTROL: begin
                    watchdog_pll_reset_en <= pwdata_i[WD_PLL_BIT];
                    watchdog_decrement_sel <= pwdata_i[WD_DEC_HI:WD_DEC_LO];
                    watchdog_threshold_sel <= pwdata_i[WD_THR_HI:WD_THR_LO];
                end
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Decoded configuration outputs
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pll_multiplier_q2_o <= MPY_Q2_X5;
            pll_multiplier_valid_o <= 1'b1;
        end else begin
            pll_multiplier_valid_o <= 1'b1;
            unique case (pll_multiplier)
                MPY_CODE_X4: pll_multiplier_q2_o <= MPY_Q2_X4;
                MPY_CODE_X5: pll_multiplier_q2_o <= MPY_Q2_X5;
                MPY_CODE_X8P25: pll_multiplier_q2_o <= MPY_Q2_X8P25;
                MPY_CODE_X10: pll_multiplier_q2_o <= MPY_Q2_X10;
                default: begin
                    pll_multiplier_q2_o <= '0;
                    pll_multiplier_valid_o <= 1'b0;
                end
            endcase
        end
    end

    // Lane multiplier, test mode and reference divisor status.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            lane_multiplier_q1_o <= RATE_Q1_00;
            prbs_test_select_o <= RST_PRBS_SEL;
            prbs_active_o <= 1'b0;
            ref_clock_divisor_o <= RST_REF_DIV;
            ref_divisor_legal_o <= 1'b1;
            vco_low_band_o <= RST_VCO_LOW;
        end else begin
            unique case (lane_rate)
                2'h0: lane_multiplier_q1_o <= RATE_Q1_00;
                2'h1: lane_multiplier_q1_o <= RATE_Q1_01;
                2'h2: lane_multiplier_q1_o <= RATE_Q1_10;
                default: lane_multiplier_q1_o <= RATE_Q1_11;
            endcase
            // Reserved test codes fall back to normal operation.
            prbs_test_select_o <= (prbs_test_select <= PRBS_LAST_CODE) ? prbs_test_select
                                                                       : RST_PRBS_SEL;
            prbs_active_o <= (prbs_test_select != RST_PRBS_SEL)
                             && (prbs_test_select <= PRBS_LAST_CODE);
            ref_clock_divisor_o <= ref_clock_divisor;
            ref_divisor_legal_o <= ref_clock_divisor inside {6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
                6'h08, 6'h0A, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h20, 6'h28, 6'h30};
            vco_low_band_o <= vco_low_band;
        end
    end

    // SYNC output, active low; the manual request overrides the link logic.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sync_n_o <= 1'b0;
        end else begin
            sync_n_o <= manual_link_request_n & link_sync_n_i;
        end
    end

    // ****************************************************************
    // Watchdog
    // ****************************************************************
    srxcfg_watchdog u_watchdog (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .link_enable_i(link_enable_i),
        .link_up_i(link_up_i),
        .crc_fault_i(crc_fault_i),
        .watchdog_pll_reset_en_i(watchdog_pll_reset_en),
        .watchdog_decrement_sel_i(watchdog_decrement_sel),
        .watchdog_threshold_sel_i(watchdog_threshold_sel),
        .phy_rx_reset_o(wd_rx_reset),
        .phy_pll_reset_o(wd_pll_reset),
        .count_o(wd_count)
    );

    // Watchdog pulses are registered once more to keep outputs at flip-flops.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            phy_rx_reset_o <= 1'b0;
            phy_pll_reset_o <= 1'b0;
        end else begin
            phy_rx_reset_o <= wd_rx_reset;
            phy_pll_reset_o <= wd_pll_reset;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_sync_manual_force: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !manual_link_request_n |=> !sync_n_o)
        else $error("Manual request did not assert SYNC");
    a_sync_follow_link: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        manual_link_request_n |=> sync_n_o == $past(link_sync_n_i))
        else $error("SYNC did not follow link");
    a_mpy_decode: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (pll_multiplier == MPY_CODE_X8P25) |=> pll_multiplier_q2_o == MPY_Q2_X8P25)
        else $error("Multiplier 8.25 misdecoded");
    a_rate_half: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (lane_rate == 2'h3) |=> lane_multiplier_q1_o == RATE_Q1_11)
        else $error("Lane rate 0.5 misdecoded");
    a_prbs_reserved: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (prbs_test_select > PRBS_LAST_CODE) |=> !prbs_active_o)
        else $error("Reserved test code enabled PRBS");
    a_wdog_readback: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (access && !pwrite_i && index == IDX_LINK_WATCHDOG_CONTROL) |=>
        prdata_o[6] == 1'b0 && prdata_o[3] == 1'b0
        && prdata_o[WD_PLL_BIT] == watchdog_pll_reset_en)
        else $error("Watchdog control layout wrong");
    a_wd_pll_pair: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wd_pll_reset |=> phy_pll_reset_o && phy_rx_reset_o)
        else $error("PLL reset not paired with receiver reset");
    a_wd_count_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wd_rx_reset |-> wd_count == '0)
        else $error("Counter not cleared on expiry");
    a_apb_answer: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (psel_i && !penable_i) ##1 (psel_i && penable_i) |=> pready_o)
        else $error("APB answer late");
    c_manual_sync: cover property (@(posedge ref_clk_i) !manual_link_request_n ##1 !sync_n_o);
    c_prbs31: cover property (@(posedge ref_clk_i) prbs_active_o && prbs_test_select_o == 5'h04);
    c_unmapped: cover property (@(posedge ref_clk_i) pready_o && pslverr_o);
    c_wd_rx_only: cover property (@(posedge ref_clk_i) phy_rx_reset_o && !phy_pll_reset_o);
endmodule : srxcfg_top

// ### hdl/srxcfg_watchdog.sv
// Link watchdog that resets the receiver PHY when uptime falls short.
`timescale 1ns/10ps
module srxcfg_watchdog
    import srxcfg_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic link_enable_i,
    input wire logic link_up_i,
    input wire logic crc_fault_i,
    input wire logic watchdog_pll_reset_en_i,
    input wire logic [1:0] watchdog_decrement_sel_i,
    input wire logic [2:0] watchdog_threshold_sel_i,
    output logic phy_rx_reset_o,
    output logic phy_pll_reset_o,
    output logic [WD_CNT_W-1:0] count_o
);
    logic [WD_CNT_W-1:0] threshold;
    logic [WD_CNT_W-1:0] decrement;
    logic armed;
    logic good;
    logic expire;

    // Threshold lookup; code 0 and the reserved codes leave the watchdog idle.
    always_comb begin
        armed = 1'b1;
        threshold = WD_THR_1;
        unique case (watchdog_threshold_sel_i)
            3'h1: threshold = WD_THR_1;
            3'h2: threshold = WD_THR_2;
            3'h3: threshold = WD_THR_3;
            3'h4: threshold = WD_THR_4;
            default: armed = 1'b0;
        endcase
    end

    // Decrement step per cycle of good link.
    always_comb begin
        unique case (watchdog_decrement_sel_i)
            2'h0: decrement = WD_DEC_0;
            2'h1: decrement = WD_DEC_1;
            2'h2: decrement = WD_DEC_2;
            default: decrement = WD_DEC_3;
        endcase
    end

    assign good = link_up_i & ~crc_fault_i;
    assign expire = armed & link_enable_i & ~good & (count_o >= threshold - WD_INC_DOWN);

    // Counter climbs while the link is bad and drains while it is good.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !link_enable_i || !armed || expire) begin
            count_o <= '0;
        end else if (good) begin
            count_o <= (count_o > decrement) ? count_o - decrement : '0;
        end else begin
            count_o <= count_o + WD_INC_DOWN;
        end
    end

    // One-cycle reset pulses on expiry; the PLL joins only when enabled.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            phy_rx_reset_o <= 1'b0;
            phy_pll_reset_o <= 1'b0;
        end else begin
            phy_rx_reset_o <= expire;
            phy_pll_reset_o <= expire & watchdog_pll_reset_en_i;
        end
    end

    a_wd_pll_follows: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        phy_pll_reset_o |-> phy_rx_reset_o)
        else $error("PLL reset without receiver reset");
    a_wd_disabled: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (watchdog_threshold_sel_i == 3'h0) |=> !phy_rx_reset_o)
        else $error("Watchdog fired while disabled");
    // The step is worked out from the select code, not taken from the lookup it checks.
    a_wd_drain_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (link_enable_i && armed && good && count_o > decrement) |=>
        count_o == $past(count_o) - (($past(watchdog_decrement_sel_i) == 2'h0) ? WD_DEC_0
        : ($past(watchdog_decrement_sel_i) == 2'h1) ? WD_DEC_1
        : ($past(watchdog_decrement_sel_i) == 2'h2) ? WD_DEC_2 : WD_DEC_3))
        else $error("Wrong watchdog decrement");
    c_wd_expiry: cover property (@(posedge ref_clk_i) phy_pll_reset_o);
endmodule : srxcfg_watchdog
